// ---- verilog/gauge_alert_map.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and word-aligned Wishbone byte addresses
`ifndef GAUGE_ALERT_MAP_SVH
`define GAUGE_ALERT_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define CFG_OFS 8'h00
`define THR_OFS 8'h04
`define STEP_OFS 8'h08
`define DCAP_OFS 8'h0C
`define CMD_OFS 8'h10
`define STAT_OFS 8'h14
// ****************************************
// operation configuration fields
// ****************************************
`define CFG_TEMPCOMP 15
`define CFG_PIN_SEL 13
`define CFG_PULLUP 12
`define CFG_ADC_GROUND_SEL 11
`define CFG_SLEEP 5
`define CFG_REMCAP 4
`define CFG_LOWBATT 2
`define CFG_POL 1
`define CFG_HOSTTEMP 0
`define CFG_RESET 16'h01F8
// ****************************************
// other reset values and command bits
// ****************************************
`define THR_RESET 32'h0502_0F0A
`define STEP_RESET 8'h0A
`define DCAP_RESET 16'h053C
`define CMD_INSERT 0
`define CMD_REMOVE 1
`define CMD_RESTORE 2
`define SOC_FULL 8'h64
// ****************************************
// state thresholds: capacity over divisor, divisors scaled by ten
// ****************************************
`define CHG_DIV_X10 20'h0_0085
`define DSG_DIV_X10 20'h0_00A7
`define QUIT_DIV_X10 20'h0_00FA
`define DIV_SCALE 20'h0_000A
// ****************************************
// timing
// ****************************************
`define CLK_MHZ 100
`define ALERT_PULSE_US 1000
`endif

// ---- verilog/gauge_alert_pkg.sv ----
// types shared by the gauge configuration and alert block
// assumes the map header supplies all numeric constants
package gauge_alert_pkg;
	typedef enum logic [1:0] {
		ST_RELAX = 2'b00,
		ST_CHG = 2'b01,
		ST_DSG = 2'b10
	} batt_state_e;
	// low-charge thresholds in percent, as one register word
	typedef struct packed {
		logic [7:0] final_clr;
		logic [7:0] final_set;
		logic [7:0] low_clr;
		logic [7:0] low_set;
	} thr_s;
endpackage

// ---- verilog/gauge_alert.sv ----
// configuration word, battery state classifier, low-charge flags and alert pin
// assumes soc, current and charge termination come from the gauging core, synchronous to clk_i
// Functional notes
// R01: sense compensation enabled by config bit
// R02: insertion source is pin or command
// R03: internal pull-up only when bit set
// R04: ground bit picks alternate ADC ground
// R05: sleep allowed only while bit set
// R06: load capacity on charge termination
// R07: function bit selects low-battery or interrupt
// R08: polarity bit sets alert active level
// R09: host may write temperature when set
// R10: host keeps reserved bits at defaults
// R11: low-battery mode alert tracks low flag
// R12: low flag set/clear at set threshold
// R13: final flag uses set and clear thresholds
// R14: each interrupt event gives 1 ms pulse
// R15: charge crossing boundary upward gives pulse
// R16: discharge falling below boundary gives pulse
// R17: battery state change gives pulse; code does so only while step_reg is nonzero
// R18: pack removal on pin gives pulse
// R19: state classified by current thresholds
// R20: restore command pulses factory restore
// R21: host drives pin edges or commands
// R22: alert rests inactive; pulse not extended
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`include "gauge_alert_map.svh"
`timescale 1ns/10ps
`default_nettype none
module gauge_alert #(
	parameter int PULSE_CYCLES = `ALERT_PULSE_US * `CLK_MHZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [7:0] soc_i,
	input wire logic signed [15:0] avg_current_i,
	input wire logic charge_term_i,
	input wire logic sleep_ok_i,
	input wire logic insert_detect_pin_i,
	output logic alert_pin_o,
	output logic sense_tempcomp_en_o,
	output logic insert_pin_pullup_en_o,
	output logic adc_ground_sel_o,
	output logic host_temp_write_en_o,
	output logic sleep_allow_o,
	output logic remcap_load_o,
	output logic factory_restore_o,
	output logic pack_present_o,
	output gauge_alert_pkg::batt_state_e batt_state_o
);
	import gauge_alert_pkg::*;

	localparam int CW = $clog2(PULSE_CYCLES + 1);
	localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYCLES - 1);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// count of boundaries above s: ceil((100 - s) / step)
	function automatic logic [7:0] step_idx(input logic [7:0] s, input logic [7:0] st);
		logic [8:0] d;
		logic [7:0] c;
		d = 9'h000;
		c = (s > `SOC_FULL) ? `SOC_FULL : s;
		if (st == 8'h00) begin
			return 8'h00;
		end
		d = {1'b0, `SOC_FULL} - {1'b0, c} + {1'b0, st} - 9'h001;
		return 8'(d / {1'b0, st});
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic [15:0] cfg_reg;
	thr_s thr_reg;
	logic [7:0] step_reg;
	logic [15:0] dcap_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic low_flag_reg;
	logic final_flag_reg;
	batt_state_e state_reg;
	batt_state_e state_next;
	logic [7:0] soc_prev_reg;
	logic pin_prev_reg;
	logic present_reg;
	logic present_next;
	logic busy_reg;
	logic [CW-1:0] cnt_reg;
	logic alert_reg;
	logic sleep_reg;
	logic remcap_reg;
	logic restore_reg;

	// ****************************************
	// bus decode
	// ****************************************
	wire logic req = cyc_i & stb_i & ~ack_reg;
	wire logic wr = req & we_i;
	wire logic hit_cfg = adr_i[7:2] == `CFG_OFS >> 2;
	wire logic hit_thr = adr_i[7:2] == `THR_OFS >> 2;
	wire logic hit_step = adr_i[7:2] == `STEP_OFS >> 2;
	wire logic hit_dcap = adr_i[7:2] == `DCAP_OFS >> 2;
	wire logic hit_cmd = adr_i[7:2] == `CMD_OFS >> 2;
	wire logic hit_stat = adr_i[7:2] == `STAT_OFS >> 2;
	wire logic cmd_wr = wr & hit_cmd & sel_i[0];
	wire logic cmd_pack_inserted = cmd_wr & dat_i[`CMD_INSERT];
	wire logic cmd_pack_removed = cmd_wr & dat_i[`CMD_REMOVE];
	wire logic cmd_restore = cmd_wr & dat_i[`CMD_RESTORE];
	wire logic [31:0] cfg_w = merge({16'h0000, cfg_reg}, dat_i, sel_i);
	wire logic [31:0] thr_w = merge(thr_reg, dat_i, sel_i);
	wire logic [31:0] step_w = merge({24'h00_0000, step_reg}, dat_i, sel_i);
	wire logic [31:0] dcap_w = merge({16'h0000, dcap_reg}, dat_i, sel_i);
	wire logic [31:0] stat_word = {24'h00_0000, alert_reg, busy_reg, present_reg, state_reg, 1'b0,
		final_flag_reg, low_flag_reg};
	wire logic [31:0] rd_mux = hit_cfg ? {16'h0000, cfg_reg} :
		hit_thr ? thr_reg :
		hit_step ? {24'h00_0000, step_reg} :
		hit_dcap ? {16'h0000, dcap_reg} :
		hit_stat ? stat_word : 32'h0000_0000;

	// ****************************************
	// configuration word
	// ****************************************
	// R10: reserved bits kept as written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= `CFG_RESET;
			thr_reg <= `THR_RESET;
			step_reg <= `STEP_RESET;
			dcap_reg <= `DCAP_RESET;
		end else if (wr) begin
			if (hit_cfg) cfg_reg <= cfg_w[15:0];
			if (hit_thr) thr_reg <= thr_w;
			if (hit_step) step_reg <= step_w[7:0];
			if (hit_dcap) dcap_reg <= dcap_w[15:0];
		end
	end

	// single-wait-state slave; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			rdata_reg <= req ? rd_mux : 32'h0000_0000;
		end
	end

	// R01: compensation enable
	assign sense_tempcomp_en_o = cfg_reg[`CFG_TEMPCOMP];
	// R03: internal pull-up enable
	assign insert_pin_pullup_en_o = cfg_reg[`CFG_PULLUP];
	// R04: converter ground select
	assign adc_ground_sel_o = cfg_reg[`CFG_ADC_GROUND_SEL];
	// R09: host temperature write
	assign host_temp_write_en_o = cfg_reg[`CFG_HOSTTEMP];
	assign dat_o = rdata_reg;
	assign ack_o = ack_reg;

	// ****************************************
	// battery state classifier
	// ****************************************
	wire logic [19:0] dcap_x = {4'h0, dcap_reg} * `DIV_SCALE;
	wire logic [19:0] chg_thr = dcap_x / `CHG_DIV_X10;
	wire logic [19:0] dsg_thr = dcap_x / `DSG_DIV_X10;
	wire logic [19:0] quit_thr = dcap_x / `QUIT_DIV_X10;
	wire logic signed [20:0] cur_x = {{5{avg_current_i[15]}}, avg_current_i};
	wire logic is_chg = cur_x > $signed({1'b0, chg_thr});
	wire logic is_dsg = cur_x < -$signed({1'b0, dsg_thr});
	wire logic is_quit = (cur_x < $signed({1'b0, quit_thr})) && (cur_x > -$signed({1'b0, quit_thr}));
	// R19: threshold classification, hold in the dead band
	assign state_next = is_chg ? ST_CHG : is_dsg ? ST_DSG : is_quit ? ST_RELAX : state_reg;

	// ****************************************
	// low-charge flags
	// ****************************************
	// R12: one threshold sets and clears
	wire logic low_next = (soc_i < thr_reg.low_set) ? 1'b1 : (soc_i > thr_reg.low_set) ? 1'b0 : low_flag_reg;
	// R13: clear only once set, at clear threshold
	wire logic final_next = (soc_i < thr_reg.final_set) ? 1'b1 :
		(final_flag_reg && soc_i > thr_reg.final_clr) ? 1'b0 : final_flag_reg;

	// ****************************************
	// interrupt events
	// ****************************************
	wire logic step_on = step_reg != 8'h00;
	wire logic [7:0] idx_now = step_idx(soc_i, step_reg);
	wire logic [7:0] idx_prev = step_idx(soc_prev_reg, step_reg);
	// R15: upward boundary reached while charging
	wire logic ev_up = step_on && state_reg == ST_CHG && idx_now < idx_prev;
	// R16: dropped below a boundary while discharging
	wire logic ev_down = step_on && state_reg == ST_DSG && idx_now > idx_prev;
	// R17: change among the three states
	wire logic ev_state = step_on && state_next != state_reg;
	wire logic pin_sel = cfg_reg[`CFG_PIN_SEL];
	// R21: pin falls for insertion, rises for removal
	wire logic pin_rise = insert_detect_pin_i & ~pin_prev_reg;
	wire logic pin_fall = ~insert_detect_pin_i & pin_prev_reg;
	// R18: removal seen on the pin
	wire logic ev_remove = pin_sel & pin_rise;
	wire logic lowbatt_function_sel = cfg_reg[`CFG_LOWBATT];
	// R22: busy pulse ignores new events
	wire logic start = ~lowbatt_function_sel & ~busy_reg & (ev_up | ev_down | ev_state | ev_remove);
	wire logic pulse_end = busy_reg && cnt_reg == PULSE_LAST;
	// R02: pin edges or host commands set presence
	assign present_next = pin_sel ? (pin_fall ? 1'b1 : pin_rise ? 1'b0 : present_reg) :
		(cmd_pack_inserted ? 1'b1 : cmd_pack_removed ? 1'b0 : present_reg);
	// R07: function select; R11 flag tracking
	wire logic active = lowbatt_function_sel ? low_flag_reg : busy_reg;
	// R08: polarity picks the active level
	wire logic alert_next = cfg_reg[`CFG_POL] ? active : ~active;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_flag_reg <= 1'b0;
			final_flag_reg <= 1'b0;
			state_reg <= ST_RELAX;
			soc_prev_reg <= 8'h00;
			pin_prev_reg <= 1'b1;
			present_reg <= 1'b0;
		end else begin
			low_flag_reg <= low_next;
			final_flag_reg <= final_next;
			state_reg <= state_next;
			soc_prev_reg <= soc_i;
			pin_prev_reg <= insert_detect_pin_i;
			present_reg <= present_next;
		end
	end

	// R14: fixed-length pulse counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_reg <= 1'b0;
			cnt_reg <= '0;
		end else if (start) begin
			busy_reg <= 1'b1;
			cnt_reg <= '0;
		end else if (busy_reg) begin
			busy_reg <= ~pulse_end;
			cnt_reg <= pulse_end ? '0 : cnt_reg + CW'(1);
		end
	end

	// R05: sleep permit; R06: capacity load; R20: restore
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// R22: rest level of the default active-low polarity
			alert_reg <= 1'b1;
			sleep_reg <= 1'b0;
			remcap_reg <= 1'b0;
			restore_reg <= 1'b0;
		end else begin
			alert_reg <= alert_next;
			sleep_reg <= cfg_reg[`CFG_SLEEP] & sleep_ok_i;
			remcap_reg <= cfg_reg[`CFG_REMCAP] & charge_term_i;
			restore_reg <= cmd_restore;
		end
	end

	assign alert_pin_o = alert_reg;
	assign sleep_allow_o = sleep_reg;
	assign remcap_load_o = remcap_reg;
	assign factory_restore_o = restore_reg;
	assign pack_present_o = present_reg;
	assign batt_state_o = state_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_start;
		!busy_reg ##1 busy_reg && cnt_reg == '0;
	endsequence
	sequence seq_end;
		busy_reg && cnt_reg == PULSE_LAST ##1 !busy_reg;
	endsequence

	a_pulse_start: assert property (start |=> busy_reg && cnt_reg == '0) // R14
		else $error("pulse did not start from zero");
	a_pulse_length: assert property (busy_reg && cnt_reg == PULSE_LAST |=> !busy_reg) // R14
		else $error("pulse length wrong");
	a_pulse_noextend: assert property (busy_reg && cnt_reg != PULSE_LAST |=> busy_reg && cnt_reg == $past(cnt_reg) + CW'(1)) // R22
		else $error("pulse restarted or stalled");
	a_state_pulse: assert property (!lowbatt_function_sel && !busy_reg && ev_state |-> seq_start) // R17
		else $error("state change gave no pulse");
	a_removal_pulse: assert property (!lowbatt_function_sel && !busy_reg && ev_remove |=> busy_reg && !pack_present_o) // R18
		else $error("removal gave no pulse");
	a_lowbatt_track: assert property (lowbatt_function_sel ##1 lowbatt_function_sel |-> alert_pin_o == ($past(cfg_reg[`CFG_POL]) ~^ $past(low_flag_reg))) // R11
		else $error("alert does not follow low flag");
	a_rest_level: assert property (seq_end ##1 !lowbatt_function_sel && !busy_reg |-> alert_pin_o == ~cfg_reg[`CFG_POL]) // R08
		else $error("alert not at rest level");
	a_low_set: assert property (soc_i < thr_reg.low_set |=> low_flag_reg) // R12
		else $error("low flag not set");
	a_final_clear: assert property (final_flag_reg && soc_i > thr_reg.final_clr && soc_i >= thr_reg.final_set |=> !final_flag_reg) // R13
		else $error("final flag not cleared");
	a_remcap_load: assert property (cfg_reg[`CFG_REMCAP] && charge_term_i |=> remcap_load_o) // R06
		else $error("capacity load missing");
	a_sleep_gate: assert property (!cfg_reg[`CFG_SLEEP] |=> !sleep_allow_o) // R05
		else $error("sleep allowed while not permitted");
	a_restore_cmd: assert property (cmd_restore |=> factory_restore_o ##1 !factory_restore_o || cmd_restore) // R20
		else $error("restore pulse missing");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held two cycles");
endmodule
`default_nettype wire

// ---- bench/gauge_host_model.sv ----
// host side bus master for the gauge alert block
// assumes a classic wishbone slave on clk_i
`include "gauge_alert_map.svh"
`timescale 1ns/10ps
`default_nettype none
module gauge_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] rdat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	// ****************
	// bus cycle
	// ****************
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		logic [31:0] v;
		v = d;
		if (a == `CFG_OFS) v = (v & 32'hFFFF_B9FF) | 32'h0000_01C8;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= v;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = rdat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// released data line must not keep a stale value
		dat_o <= ~v;
	endtask
endmodule
`default_nettype wire

// ---- bench/gauge_alert_tb.sv ----
// self-checking bench for the gauge configuration and alert block
// assumes the host model as bus master and a short pulse parameter
`include "gauge_alert_map.svh"
`timescale 1ns/10ps
`default_nettype none
module gauge_alert_tb;
	import gauge_alert_pkg::*;
	localparam int PC = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, alert, comp, pull, gnd, htw, slp, rml, rsto, pres;
	logic term = 1'b0;
	logic slok = 1'b0;
	logic pin = 1'b1;
	logic [7:0] adr;
	logic [7:0] soc = 8'h32;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic signed [15:0] cur = 16'sh0000;
	batt_state_e st;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	int restores = 0;
	always #5 clk_i = ~clk_i;
	gauge_host_model host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat));
	gauge_alert #(.PULSE_CYCLES(PC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .soc_i(soc), .avg_current_i(cur),
		.charge_term_i(term), .sleep_ok_i(slok), .insert_detect_pin_i(pin), .alert_pin_o(alert),
		.sense_tempcomp_en_o(comp), .insert_pin_pullup_en_o(pull), .adc_ground_sel_o(gnd),
		.host_temp_write_en_o(htw), .sleep_allow_o(slp), .remcap_load_o(rml), .factory_restore_o(rsto),
		.pack_present_o(pres), .batt_state_o(st));
	// ****************
	// helpers
	// ****************
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (rsto === 1'b1) restores <= restores + 1;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0000_0000, q);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic setsoc(input logic [7:0] v);
		@(posedge clk_i);
		soc <= v;
		tick(4);
	endtask
	// one pulse; a soc change injected mid-pulse must not stretch it
	task automatic pulse(input logic [7:0] inj);
		int n;
		n = 0;
		while (alert !== 1'b0 && n < 8) begin
			@(posedge clk_i);
			n++;
		end
		soc <= inj;
		chk(n < 8, 1);
		n = 0;
		while (alert === 1'b0 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		chk(n, PC);
	endtask
	task automatic quiet();
		repeat (30) begin
			@(posedge clk_i);
			chk(alert, 1'b1);
		end
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		rd(`CFG_OFS);
		chk(q, 32'h0000_01F8);
		rd(`THR_OFS);
		chk(q, 32'h0502_0F0A);
		wr(8'h1C, 32'hFFFF_FFFF);
		rd(8'h1C);
		chk(q, 32'h0000_0000);
		chk({comp, pull, gnd, htw, alert, st}, 7'b0000_100);
		$display("reset test done");
	endtask
	task automatic t_cfg();
		wr(`CFG_OFS, 32'h0000_99F9);
		chk({comp, pull, gnd, htw}, 4'hF);
		slok <= 1'b1;
		term <= 1'b1;
		tick(2);
		chk({slp, rml}, 2'b11);
		wr(`CFG_OFS, 32'h0000_99C9);
		tick(2);
		chk({slp, rml}, 2'b00);
		wr(`CFG_OFS, 32'h0000_01F8);
		chk({comp, pull, gnd, htw}, 4'h0);
		$display("config test done");
	endtask
	task automatic t_low();
		wr(`CFG_OFS, 32'h0000_01FC);
		setsoc(8'h05);
		chk(alert, 1'b0);
		rd(`STAT_OFS);
		chk(q[1:0], 2'b01);
		setsoc(8'h01);
		rd(`STAT_OFS);
		chk(q[1:0], 2'b11);
		setsoc(8'h04);
		rd(`STAT_OFS);
		chk(q[1:0], 2'b11);
		setsoc(8'h06);
		rd(`STAT_OFS);
		chk(q[1:0], 2'b01);
		setsoc(8'h0B);
		chk(alert, 1'b1);
		wr(`CFG_OFS, 32'h0000_01FE);
		setsoc(8'h05);
		chk(alert, 1'b1);
		setsoc(8'h32);
		wr(`CFG_OFS, 32'h0000_01F8);
		tick(40);
		chk(alert, 1'b1);
		$display("low battery test done");
	endtask
	task automatic t_int();
		cur <= 16'sd500;
		pulse(8'h32);
		chk(st, 2'b01);
		setsoc(8'h37);
		quiet();
		soc <= 8'h3C;
		pulse(8'h46);
		quiet();
		cur <= -16'sd500;
		pulse(8'h46);
		chk(st, 2'b10);
		soc <= 8'h45;
		pulse(8'h45);
		cur <= 16'sd0;
		pulse(8'h45);
		wr(`STEP_OFS, 32'h0000_0000);
		cur <= 16'sd500;
		quiet();
		$display("interrupt test done");
	endtask
	task automatic t_pin();
		wr(`CFG_OFS, 32'h0000_21F8);
		pin <= 1'b0;
		tick(3);
		chk(pres, 1'b1);
		pin <= 1'b1;
		pulse(8'h45);
		chk(pres, 1'b0);
		wr(`CFG_OFS, 32'h0000_01F8);
		pin <= 1'b0;
		tick(3);
		chk(pres, 1'b0);
		wr(`CMD_OFS, 32'h0000_0001);
		tick(2);
		chk(pres, 1'b1);
		wr(`CMD_OFS, 32'h0000_0002);
		tick(2);
		chk(pres, 1'b0);
		wr(`CMD_OFS, 32'h0000_0004);
		tick(2);
		chk(restores, 1);
		$display("detect test done");
	endtask
	initial begin
		tick(3);
		rst_i <= 1'b0;
		t_reset();
		t_cfg();
		t_low();
		t_int();
		t_pin();
		conclude();
	end
endmodule
`default_nettype wire
